// ### src/tape_sense_mode_reporting.sv
// density legality, medium type and sense reporting for a tape target
// assumes command strobes come from logic on the same clock, one cycle each
//
// Functional notes
// R1 - at start of tape, density sets default
// R2 - write legality: code must equal default density
// R3 - read legality: code must equal tape format
// R4 - read legality: echoed sensed density always accepted
// R5 - medium type byte from cartridge when enabled
// R6 - medium type byte zero when disabled
// R7 - native mode keeps sense after request sense
// R8 - native mode: error counter in bytes 16-18
// R9 - native, code CAh: log page/param bytes 8-9
// R10 - clearing mode zeroes key, ASC, ASCQ, code
// R11 - clearing mode: key specific bytes 15-17
// R12 - clearing, code CAh: threshold pointers bytes 15-17
// R13 - full format returns 29 bytes
// R14 - no-code format returns 28 bytes
// R15 - legacy format 26 bytes, never deferred
// R16 - request sense never changes the options
// R17 - defaults: write, medium on, native, full
// R18 - options load once from storage, then fixed
`timescale 1ns/1ps
`default_nettype none
module tape_sense_mode_reporting #(
    parameter logic [7:0] DEF_DENSITY = 8'h00
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // option load from nonvolatile storage
    input wire logic nvLoad,
    input wire logic nvLegalRead,
    input wire logic nvMediumReport,
    input wire logic nvSenseClear,
    input wire logic [1:0] nvSenseFormat,
    output logic optLoaded,
    // tape state
    input wire logic logical_tape_start,
    input wire logic [7:0] tapeFormat,
    input wire logic [7:0] cartridgeType,
    // mode select
    input wire logic modeSelReq,
    input wire logic [7:0] modeSelDensity,
    output logic modeSelAccept,
    output logic modeSelReject,
    output logic [7:0] defaultDensity,
    // mode sense
    input wire logic modeSenseReq,
    output logic modeSenseDone,
    output logic [7:0] mediumType,
    output logic [7:0] reportedDensity,
    // sense data load
    input wire logic senseLoad,
    input wire logic senseDeferred,
    input wire logic [3:0] senseKeyIn,
    input wire logic [7:0] ascIn,
    input wire logic [7:0] ascqIn,
    input wire logic [7:0] fault_symptom_code,
    input wire logic [23:0] errCountIn,
    input wire logic [7:0] logPageIn,
    input wire logic [7:0] logParamIn,
    input wire logic [23:0] keySpecificIn,
    // request sense
    input wire logic reqSenseReq,
    output logic reqSenseBusy,
    output logic senseValid,
    output logic [7:0] senseData,
    output logic senseLast,
    output logic senseGood,
    output logic [3:0] senseKey
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    typedef enum logic [1:0] {RS_IDLE, RS_SEND, RS_STATUS} rsState_t;

    logic optLoaded_r, legalRead_r, mediumReport_r, senseClear_r;
    logic [1:0] senseFormat_r;
    logic [7:0] defaultDensity_r, mediumType_r, reportedDensity_r;
    logic accept_r, reject_r, msDone_r, selOk;
    logic deferred_r;
    logic [3:0] key_r;
    logic [7:0] asc_r, ascq_r, fsc_r, logPage_r, logParam_r;
    logic [23:0] errCount_r, keySpec_r;
    rsState_t rsState_r;
    logic [4:0] rsIdx_r, outIdx_r, rsLen;
    logic [7:0] muxByte, rsData_r;
    logic rsValid_r, rsLast_r, rsGood_r;

    // options: reset defaults, then one load; later loads ignored
    always_ff @(posedge clock) begin
        if (rst) begin
            optLoaded_r <= 1'b0;
            legalRead_r <= tape_opts_pkg::DEF_LEGAL; // see R17
            mediumReport_r <= tape_opts_pkg::DEF_MEDIUM_REPORT; // see R17
            senseClear_r <= tape_opts_pkg::DEF_SMODE; // see R17
            senseFormat_r <= tape_opts_pkg::DEF_FMT; // see R17
        end else if (nvLoad && !optLoaded_r) begin
            // no command path reaches these flops
            optLoaded_r <= 1'b1; // see R18
            legalRead_r <= nvLegalRead; // see R18
            mediumReport_r <= nvMediumReport;
            senseClear_r <= nvSenseClear; // see R16
            senseFormat_r <= nvSenseFormat; // see R16
        end
    end

    // density legality away from start of tape
    always_comb begin
        if (legalRead_r == tape_opts_pkg::LEGAL_READ) begin
            selOk = (modeSelDensity == tapeFormat) || (modeSelDensity == reportedDensity_r); // see R3 R4
        end else begin
            selOk = (modeSelDensity == defaultDensity_r); // see R2
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            defaultDensity_r <= DEF_DENSITY;
            accept_r <= 1'b0;
            reject_r <= 1'b0;
        end else begin
            accept_r <= 1'b0;
            reject_r <= 1'b0;
            if (modeSelReq) begin
                if (logical_tape_start) begin
                    defaultDensity_r <= modeSelDensity; // see R1
                    accept_r <= 1'b1;
                end else begin
                    // format cannot change mid tape
                    accept_r <= selOk;
                    reject_r <= !selOk;
                end
            end
        end
    end

    // mode sense header values
    always_ff @(posedge clock) begin
        if (rst) begin
            mediumType_r <= tape_opts_pkg::MEDIUM_NONE;
            reportedDensity_r <= DEF_DENSITY;
            msDone_r <= 1'b0;
        end else begin
            msDone_r <= modeSenseReq;
            if (modeSenseReq) begin
                // cartridge code passed through as the medium code
                mediumType_r <= mediumReport_r ? cartridgeType : tape_opts_pkg::MEDIUM_NONE; // see R5 R6
                reportedDensity_r <= tapeFormat;
            end
        end
    end

    // sense store; a fresh load beats the clear
    always_ff @(posedge clock) begin
        if (rst) begin
            deferred_r <= 1'b0;
            key_r <= 4'h0;
            asc_r <= 8'h00;
            ascq_r <= 8'h00;
            fsc_r <= 8'h00;
            errCount_r <= 24'h000000;
            logPage_r <= 8'h00;
            logParam_r <= 8'h00;
            keySpec_r <= 24'h000000;
        end else if (senseLoad) begin
            deferred_r <= senseDeferred;
            key_r <= senseKeyIn;
            asc_r <= ascIn;
            ascq_r <= ascqIn;
            fsc_r <= fault_symptom_code;
            errCount_r <= errCountIn;
            logPage_r <= logPageIn;
            logParam_r <= logParamIn;
            keySpec_r <= keySpecificIn;
        end else if (rsGood_r && senseClear_r == tape_opts_pkg::SMODE_CLEAR) begin
            // cleared only once good status has gone out
            key_r <= 4'h0; // see R10
            asc_r <= 8'h00; // see R10
            ascq_r <= 8'h00; // see R10
            fsc_r <= 8'h00; // see R10
            deferred_r <= 1'b0;
        end
        // native mode: nothing here touches the store, see R7
    end

    always_comb begin
        case (senseFormat_r)
            tape_opts_pkg::FMT_NOFSC: rsLen = tape_opts_pkg::LEN_NOFSC; // see R14
            tape_opts_pkg::FMT_LEGACY: rsLen = tape_opts_pkg::LEN_LEGACY; // see R15
            default: rsLen = tape_opts_pkg::LEN_FULL; // see R13
        endcase
    end

    sense_byte_sel u_sel (
        .idx(rsIdx_r),
        .fmt(senseFormat_r),
        .clearMode(senseClear_r),
        .deferred(deferred_r),
        .senseKey(key_r),
        .asc(asc_r),
        .ascq(ascq_r),
        .faultSymptomCode(fsc_r),
        .errCount(errCount_r),
        .logPage(logPage_r),
        .logParam(logParam_r),
        .keySpecific(keySpec_r),
        .dataByte(muxByte)
    );

    // request sense byte stream, one byte per cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            rsState_r <= RS_IDLE;
            rsIdx_r <= 5'h00;
            outIdx_r <= 5'h00;
            rsData_r <= 8'h00;
            rsValid_r <= 1'b0;
            rsLast_r <= 1'b0;
            rsGood_r <= 1'b0;
        end else begin
            rsValid_r <= 1'b0;
            rsLast_r <= 1'b0;
            rsGood_r <= 1'b0;
            case (rsState_r)
                RS_IDLE: begin
                    rsIdx_r <= 5'h00;
                    if (reqSenseReq) begin
                        rsState_r <= RS_SEND;
                    end
                end
                RS_SEND: begin
                    rsData_r <= muxByte;
                    rsValid_r <= 1'b1;
                    outIdx_r <= rsIdx_r;
                    rsIdx_r <= rsIdx_r + 5'h01;
                    if (rsIdx_r == rsLen - 5'h01) begin
                        rsLast_r <= 1'b1; // see R13 R14 R15
                        rsState_r <= RS_STATUS;
                    end
                end
                RS_STATUS: begin
                    rsGood_r <= 1'b1;
                    rsState_r <= RS_IDLE;
                end
                default: rsState_r <= RS_IDLE;
            endcase
        end
    end

    // bytes actually sent; independent of rsIdx_r so a bad index is caught
    logic [4:0] sentCnt_r;
    always_ff @(posedge clock) begin
        if (rst || rsState_r == RS_IDLE) begin
            sentCnt_r <= 5'h00;
        end else if (rsValid_r) begin
            sentCnt_r <= sentCnt_r + 5'h01;
        end
    end

    assign optLoaded = optLoaded_r;
    assign modeSelAccept = accept_r;
    assign modeSelReject = reject_r;
    assign defaultDensity = defaultDensity_r;
    assign modeSenseDone = msDone_r;
    assign mediumType = mediumType_r;
    assign reportedDensity = reportedDensity_r;
    assign reqSenseBusy = (rsState_r != RS_IDLE);
    assign senseValid = rsValid_r;
    assign senseData = rsData_r;
    assign senseLast = rsLast_r;
    assign senseGood = rsGood_r;
    assign senseKey = key_r;

    property p_start_load;
        modeSelReq && logical_tape_start |=> defaultDensity_r == $past(modeSelDensity) && accept_r;
    endproperty
    a_start_load: assert property (p_start_load) else $error("start of tape did not set density"); // see R1

    property p_write_legal;
        modeSelReq && !logical_tape_start && legalRead_r == tape_opts_pkg::LEGAL_WRITE
            |=> accept_r == ($past(modeSelDensity) == $past(defaultDensity_r)) && reject_r != accept_r;
    endproperty
    a_write_legal: assert property (p_write_legal) else $error("write legality wrong"); // see R2

    property p_read_legal;
        modeSelReq && !logical_tape_start && legalRead_r == tape_opts_pkg::LEGAL_READ
            && modeSelDensity == tapeFormat |=> accept_r && !reject_r;
    endproperty
    a_read_legal: assert property (p_read_legal) else $error("read legality refused format"); // see R3

    property p_echo;
        modeSelReq && !logical_tape_start && legalRead_r == tape_opts_pkg::LEGAL_READ
            && modeSelDensity == reportedDensity_r |=> accept_r && !reject_r;
    endproperty
    a_echo: assert property (p_echo) else $error("echoed density refused"); // see R4

    property p_medium_on;
        modeSenseReq && mediumReport_r |=> mediumType_r == $past(cartridgeType) && msDone_r;
    endproperty
    a_medium_on: assert property (p_medium_on) else $error("medium type not reported"); // see R5

    property p_medium_off;
        modeSenseReq && !mediumReport_r |=> mediumType_r == tape_opts_pkg::MEDIUM_NONE;
    endproperty
    a_medium_off: assert property (p_medium_off) else $error("medium type not zero"); // see R6

    property p_keep;
        rsGood_r && senseClear_r == tape_opts_pkg::SMODE_NATIVE && !senseLoad
            |=> key_r == $past(key_r) && fsc_r == $past(fsc_r) && asc_r == $past(asc_r);
    endproperty
    a_keep: assert property (p_keep) else $error("native sense altered"); // see R7

    property p_clear;
        rsGood_r && senseClear_r == tape_opts_pkg::SMODE_CLEAR && !senseLoad
            |=> key_r == 4'h0 && asc_r == 8'h00 && ascq_r == 8'h00 && fsc_r == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("clearing sense not cleared"); // see R10

    property p_length;
        rsValid_r && rsLast_r |-> outIdx_r == rsLen - 5'h01 ##1 rsGood_r && !rsValid_r;
    endproperty
    a_length: assert property (p_length) else $error("sense length wrong"); // see R13

    property p_byte_count;
        rsValid_r && rsLast_r |-> sentCnt_r == rsLen - 5'h01;
    endproperty
    a_byte_count: assert property (p_byte_count) else $error("byte count differs from length"); // see R14

    property p_legacy_resp;
        rsValid_r && outIdx_r == tape_opts_pkg::B_RESP && senseFormat_r == tape_opts_pkg::FMT_LEGACY
            |-> rsData_r == tape_opts_pkg::RESP_CURRENT;
    endproperty
    a_legacy_resp: assert property (p_legacy_resp) else $error("legacy deferred code"); // see R15

    property p_opts_fixed;
        optLoaded_r |=> $stable(senseClear_r) && $stable(senseFormat_r) && $stable(legalRead_r);
    endproperty
    a_opts_fixed: assert property (p_opts_fixed) else $error("options changed after load"); // see R16

    property p_defaults;
        $fell(rst) && !optLoaded_r |-> legalRead_r == tape_opts_pkg::DEF_LEGAL
            && senseFormat_r == tape_opts_pkg::DEF_FMT && mediumReport_r;
    endproperty
    a_defaults: assert property (p_defaults) else $error("option defaults wrong"); // see R17
endmodule
`default_nettype wire

// ### include/tape_opts_pkg.sv
// constants for the tape option reporting block
// assumes one 200 MHz clock and byte-wide sense data
package tape_opts_pkg;
    // option encodings
    localparam logic LEGAL_WRITE = 1'b0;
    localparam logic LEGAL_READ = 1'b1;
    localparam logic SMODE_NATIVE = 1'b0;
    localparam logic SMODE_CLEAR = 1'b1;
    localparam logic [1:0] FMT_FULL = 2'h0;
    localparam logic [1:0] FMT_NOFSC = 2'h1;
    localparam logic [1:0] FMT_LEGACY = 2'h2;
    // option defaults after reset
    localparam logic DEF_LEGAL = LEGAL_WRITE;
    localparam logic DEF_MEDIUM_REPORT = 1'b1;
    localparam logic DEF_SMODE = SMODE_NATIVE;
    localparam logic [1:0] DEF_FMT = FMT_FULL;
    // sense lengths in bytes
    localparam logic [4:0] LEN_FULL = 5'h1d;
    localparam logic [4:0] LEN_NOFSC = 5'h1c;
    localparam logic [4:0] LEN_LEGACY = 5'h1a;
    localparam logic [4:0] ADDL_BASE = 5'h08;
    // sense byte positions
    localparam logic [4:0] B_RESP = 5'h00;
    localparam logic [4:0] B_KEY = 5'h02;
    localparam logic [4:0] B_ADDL = 5'h07;
    localparam logic [4:0] B_LOGPAGE = 5'h08;
    localparam logic [4:0] B_LOGPARAM = 5'h09;
    localparam logic [4:0] B_ASC = 5'h0c;
    localparam logic [4:0] B_ASCQ = 5'h0d;
    localparam logic [4:0] B_SKS0 = 5'h0f;
    localparam logic [4:0] B_SKS1 = 5'h10;
    localparam logic [4:0] B_SKS2 = 5'h11;
    localparam logic [4:0] B_CNT0 = 5'h10;
    localparam logic [4:0] B_CNT1 = 5'h11;
    localparam logic [4:0] B_CNT2 = 5'h12;
    localparam logic [4:0] B_FSC = 5'h1c;
    // codes
    localparam logic [7:0] RESP_CURRENT = 8'h70;
    localparam logic [7:0] RESP_DEFERRED = 8'h71;
    localparam logic [7:0] FSC_THRESHOLD = 8'hca;
    localparam logic [7:0] MEDIUM_NONE = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// ### src/sense_byte_sel.sv
// picks one byte of the sense data by index
// assumes the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module sense_byte_sel (
    // selection
    input wire logic [4:0] idx,
    input wire logic [1:0] fmt,
    input wire logic clearMode,
    // stored sense fields
    input wire logic deferred,
    input wire logic [3:0] senseKey,
    input wire logic [7:0] asc,
    input wire logic [7:0] ascq,
    input wire logic [7:0] faultSymptomCode,
    input wire logic [23:0] errCount,
    input wire logic [7:0] logPage,
    input wire logic [7:0] logParam,
    input wire logic [23:0] keySpecific,
    // result
    output logic [7:0] dataByte
);
    logic [4:0] len;
    logic thresh;
    logic [23:0] sks;
    always_comb begin
        len = (fmt == tape_opts_pkg::FMT_LEGACY) ? tape_opts_pkg::LEN_LEGACY :
              (fmt == tape_opts_pkg::FMT_NOFSC) ? tape_opts_pkg::LEN_NOFSC : tape_opts_pkg::LEN_FULL;
        thresh = (faultSymptomCode == tape_opts_pkg::FSC_THRESHOLD);
        // threshold pointers take over the key specific bytes
        sks = thresh ? {logPage, logParam, tape_opts_pkg::ZERO_BYTE} : keySpecific; // see R12
        dataByte = tape_opts_pkg::ZERO_BYTE;
        if (idx == tape_opts_pkg::B_RESP) begin
            // legacy layout has no deferred form
            dataByte = (deferred && fmt != tape_opts_pkg::FMT_LEGACY) ?
                       tape_opts_pkg::RESP_DEFERRED : tape_opts_pkg::RESP_CURRENT; // see R15
        end else if (idx == tape_opts_pkg::B_KEY) begin
            dataByte = {4'h0, senseKey};
        end else if (idx == tape_opts_pkg::B_ADDL) begin
            dataByte = {3'h0, len - tape_opts_pkg::ADDL_BASE};
        end else if (idx == tape_opts_pkg::B_ASC) begin
            dataByte = asc;
        end else if (idx == tape_opts_pkg::B_ASCQ) begin
            dataByte = ascq;
        end else if (idx == tape_opts_pkg::B_FSC) begin
            dataByte = faultSymptomCode;
        end else if (!clearMode) begin
            if (thresh && idx == tape_opts_pkg::B_LOGPAGE) begin
                dataByte = logPage; // see R9
            end else if (thresh && idx == tape_opts_pkg::B_LOGPARAM) begin
                dataByte = logParam; // see R9
            end else if (idx == tape_opts_pkg::B_CNT0) begin
                dataByte = errCount[23:16]; // see R8
            end else if (idx == tape_opts_pkg::B_CNT1) begin
                dataByte = errCount[15:8]; // see R8
            end else if (idx == tape_opts_pkg::B_CNT2) begin
                dataByte = errCount[7:0]; // see R8
            end
        end else begin
            if (idx == tape_opts_pkg::B_SKS0) begin
                dataByte = sks[23:16]; // see R11
            end else if (idx == tape_opts_pkg::B_SKS1) begin
                dataByte = sks[15:8]; // see R11
            end else if (idx == tape_opts_pkg::B_SKS2) begin
                dataByte = sks[7:0]; // see R11
            end
        end
    end
endmodule
`default_nettype wire

// ### test/scsi_initiator_model.sv
// initiator side model: issues request sense and collects returned bytes
// assumes registered sense outputs from the target on the same clock
`timescale 1ns/1ps
`default_nettype none
module scsi_initiator_model (
    // clock
    input wire logic clock,
    // sense stream from target
    input wire logic senseValid,
    input wire logic [7:0] senseData,
    input wire logic senseGood,
    // command
    output logic reqSenseReq
);
    logic [7:0] capBytes [0:31];
    int cnt;

    initial reqSenseReq = 1'b0;

    always @(posedge clock) begin
        if (senseValid === 1'b1 && cnt < 32) begin
            capBytes[cnt] = senseData;
            cnt = cnt + 1;
        end
    end

    // waits on good status, bounded so a stuck target cannot hang
    task automatic read_sense(output logic [7:0] n);
        cnt = 0;
        @(posedge clock);
        reqSenseReq <= 1'b1;
        @(posedge clock);
        reqSenseReq <= 1'b0;
        repeat (40) begin
            @(posedge clock);
            if (senseGood === 1'b1) break;
        end
        @(posedge clock);
        n = cnt[7:0];
    endtask
endmodule
`default_nettype wire

// ### test/tape_sense_mode_reporting_tb.sv
// bench for density legality, medium type and sense reporting
// assumes the initiator model in the same folder
`timescale 1ns/1ps
`default_nettype none
module tape_sense_mode_reporting_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic nvLoad = 1'b0, nvLegalRead = 1'b0, nvMediumReport = 1'b0, nvSenseClear = 1'b0;
    logic [1:0] nvSenseFormat = 2'h0;
    logic logical_tape_start = 1'b0, modeSelReq = 1'b0, modeSenseReq = 1'b0;
    logic [7:0] tapeFormat = 8'h00, cartridgeType = 8'h00, modeSelDensity = 8'h00;
    logic senseLoad = 1'b0, senseDeferred = 1'b0;
    logic [3:0] senseKeyIn = 4'h0;
    logic [7:0] ascIn = 8'h00, ascqIn = 8'h00, fault_symptom_code = 8'h00;
    logic [7:0] logPageIn = 8'h00, logParamIn = 8'h00;
    logic [23:0] errCountIn = 24'h0, keySpecificIn = 24'h0;
    logic reqSenseReq, optLoaded, modeSelAccept, modeSelReject, modeSenseDone;
    logic reqSenseBusy, senseValid, senseLast, senseGood;
    logic [7:0] defaultDensity, mediumType, reportedDensity, senseData, n;
    logic [3:0] senseKey;
    int err_count = 0;
    int num_checks = 0;
    int vCnt = 0;
    int lastCnt = 0;

    always #2.5 clock = ~clock;

    tape_sense_mode_reporting u_dut (.clock(clock), .rst(rst), .nvLoad(nvLoad),
        .nvLegalRead(nvLegalRead), .nvMediumReport(nvMediumReport), .nvSenseClear(nvSenseClear),
        .nvSenseFormat(nvSenseFormat), .optLoaded(optLoaded), .logical_tape_start(logical_tape_start),
        .tapeFormat(tapeFormat), .cartridgeType(cartridgeType), .modeSelReq(modeSelReq),
        .modeSelDensity(modeSelDensity), .modeSelAccept(modeSelAccept), .modeSelReject(modeSelReject),
        .defaultDensity(defaultDensity), .modeSenseReq(modeSenseReq), .modeSenseDone(modeSenseDone),
        .mediumType(mediumType), .reportedDensity(reportedDensity), .senseLoad(senseLoad),
        .senseDeferred(senseDeferred), .senseKeyIn(senseKeyIn), .ascIn(ascIn), .ascqIn(ascqIn),
        .fault_symptom_code(fault_symptom_code), .errCountIn(errCountIn), .logPageIn(logPageIn),
        .logParamIn(logParamIn), .keySpecificIn(keySpecificIn), .reqSenseReq(reqSenseReq),
        .reqSenseBusy(reqSenseBusy), .senseValid(senseValid), .senseData(senseData),
        .senseLast(senseLast), .senseGood(senseGood), .senseKey(senseKey));

    scsi_initiator_model u_host (.clock(clock), .senseValid(senseValid), .senseData(senseData),
        .senseGood(senseGood), .reqSenseReq(reqSenseReq));

    // position of the byte flagged last, restarted by each request
    always @(posedge clock) begin
        if (reqSenseReq === 1'b1) begin
            vCnt <= 0;
            lastCnt <= 0;
        end else if (senseValid === 1'b1) begin
            vCnt <= vCnt + 1;
            if (senseLast === 1'b1) begin
                lastCnt <= vCnt + 1;
            end
        end
    end

    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
    endtask

    task automatic load(input logic lr, input logic mr, input logic sc, input logic [1:0] fmt);
        @(posedge clock);
        {nvLegalRead, nvMediumReport, nvSenseClear, nvSenseFormat} <= {lr, mr, sc, fmt};
        nvLoad <= 1'b1;
        @(posedge clock);
        nvLoad <= 1'b0;
        // optLoaded rises on the same edge that takes the load
        @(posedge clock);
    endtask

    // other fields derived from one base; errCountIn and keySpecificIn share only their top byte
    task automatic sload(input logic d, input logic [3:0] k, input logic [7:0] f, input logic [7:0] b);
        @(posedge clock);
        {senseDeferred, senseKeyIn, fault_symptom_code, ascIn, ascqIn} <= {d, k, f, b, ~b};
        errCountIn <= {b, 16'h3456};
        keySpecificIn <= {b, 16'hcdef};
        logPageIn <= b + 8'h01;
        logParamIn <= b + 8'h02;
        senseLoad <= 1'b1;
        @(posedge clock);
        senseLoad <= 1'b0;
    endtask

    task automatic msel(input logic [7:0] d, input logic start, input logic ok);
        @(posedge clock);
        {modeSelDensity, logical_tape_start, modeSelReq} <= {d, start, 1'b1};
        @(posedge clock);
        modeSelReq <= 1'b0;
        @(posedge clock);
        check("accept", {7'h0, modeSelAccept}, {7'h0, ok});
        check("reject", {7'h0, modeSelReject}, {7'h0, ~ok});
    endtask

    task automatic msense(input logic [7:0] med);
        @(posedge clock);
        modeSenseReq <= 1'b1;
        @(posedge clock);
        modeSenseReq <= 1'b0;
        @(posedge clock);
        check("done", {7'h0, modeSenseDone}, 8'h01);
        check("medium", mediumType, med);
        check("density", reportedDensity, tapeFormat);
    endtask

    task automatic sense(input logic [7:0] len);
        u_host.read_sense(n);
        check("length", n, len);
        check("lastAt", lastCnt[7:0], len);
        check("busy", {7'h0, reqSenseBusy}, 8'h00);
    endtask

    task automatic byt(input int i, input logic [7:0] exp);
        check($sformatf("byte%0d", i), u_host.capBytes[i], exp);
    endtask

    task automatic nat_chk(input logic [7:0] b);
        byt(0, 8'h71);
        byt(2, 8'h03);
        byt(8, b + 8'h01);
        byt(9, b + 8'h02);
        byt(12, b);
        byt(13, ~b);
        byt(16, b);
        byt(17, 8'h34);
        byt(18, 8'h56);
        byt(28, 8'hca);
    endtask

    initial begin
        do_reset();
        check("optLoaded", {7'h0, optLoaded}, 8'h00);
        check("defDensity", defaultDensity, 8'h00);
        sload(1'b1, 4'h3, 8'hca, 8'h40);
        sense(8'h1d);
        nat_chk(8'h40);
        sense(8'h1d);
        nat_chk(8'h40);
        check("senseKey", {4'h0, senseKey}, 8'h03);
        msel(8'h15, 1'b1, 1'b1);
        check("defDensity", defaultDensity, 8'h15);
        tapeFormat <= 8'h8c;
        msel(8'h15, 1'b0, 1'b1);
        msel(8'h8c, 1'b0, 1'b0);
        cartridgeType <= 8'h5a;
        msense(8'h5a);
        do_reset();
        load(1'b1, 1'b0, 1'b1, 2'h1);
        check("optLoaded", {7'h0, optLoaded}, 8'h01);
        load(1'b0, 1'b1, 1'b0, 2'h0);
        msense(8'h00);
        tapeFormat <= 8'h14;
        msel(8'h14, 1'b0, 1'b1);
        msel(8'h00, 1'b0, 1'b0);
        msel(8'h8c, 1'b0, 1'b1);
        sload(1'b0, 4'h5, 8'hca, 8'h60);
        sense(8'h1c);
        byt(2, 8'h05);
        byt(15, 8'h61);
        byt(16, 8'h62);
        byt(17, 8'h00);
        check("senseKey", {4'h0, senseKey}, 8'h00);
        sense(8'h1c);
        byt(2, 8'h00);
        byt(12, 8'h00);
        byt(13, 8'h00);
        sload(1'b0, 4'h5, 8'h01, 8'h60);
        sense(8'h1c);
        byt(15, 8'h60);
        byt(16, 8'hcd);
        byt(17, 8'hef);
        do_reset();
        load(1'b0, 1'b1, 1'b0, 2'h2);
        sload(1'b1, 4'h3, 8'hca, 8'h40);
        sense(8'h1a);
        byt(0, 8'h70);
        print_verdict();
    end

    // whole run is a few hundred cycles; this leaves ample margin
    initial begin
        #50000;
        err_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
